// ===== core/tpdc_pkg.sv
// constants shared by the triple pll divider configuration block
// assumes a 32-bit axi4-lite master and byte-wide pll control registers
package tpdc_pkg;

  localparam int NUM_REGS = 6;
  localparam int ADDR_W = 8;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIX_A = 8'h05;
  localparam logic [7:0] IDX_PIX_B = 8'h06;
  localparam logic [7:0] IDX_MEM_A = 8'h07;
  localparam logic [7:0] IDX_MEM_B = 8'h08;
  localparam logic [7:0] IDX_CORE_A = 8'h09;
  localparam logic [7:0] IDX_CORE_B = 8'h0A;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam logic [NUM_REGS-1:0][7:0] REG_IDX =
    {IDX_CORE_B, IDX_CORE_A, IDX_MEM_B, IDX_MEM_A, IDX_PIX_B, IDX_PIX_A};

  // slots in the register array
  localparam int SLOT_PIX_A = 0;
  localparam int SLOT_PIX_B = 1;
  localparam int SLOT_MEM_A = 2;
  localparam int SLOT_MEM_B = 3;
  localparam int SLOT_CORE_A = 4;
  localparam int SLOT_CORE_B = 5;

  // field layout of the first control register of each pll
  localparam int POST_HI = 7;
  localparam int POST_LO = 6;
  localparam int PRE_HI = 5;
  localparam int PRE_LO = 1;
  localparam int N8_BIT = 0;

  // reset values: post-divider 0, pre-divider 10, n[8] 0; multiplier low bytes 60, 133, 100
  localparam logic [7:0] CTRL_A_RST = 8'h14;
  localparam logic [7:0] PIX_B_RST = 8'h3C;
  localparam logic [7:0] MEM_B_RST = 8'h85;
  localparam logic [7:0] CORE_B_RST = 8'h64;
  localparam logic [NUM_REGS-1:0][7:0] REG_RST =
    {CORE_B_RST, CTRL_A_RST, MEM_B_RST, CTRL_A_RST, PIX_B_RST, CTRL_A_RST};

  // legal ranges and the least reference rate after the pre-divider
  localparam logic [4:0] PRE_MIN = 5'h02;
  localparam logic [8:0] MULT_MIN = 9'h002;
  localparam logic [31:0] REF_MIN_KHZ = 32'h0000_03E8;

  // status register bits
  localparam int ST_BUSY = 0;
  localparam int ST_BAD_CORE = 1;
  localparam int ST_BAD_MEM = 2;
  localparam int ST_BAD_PIX = 3;

  // frequency calculator geometry
  localparam int PROD_W = 41;
  localparam int DIV_W = 7;
  localparam logic [5:0] CALC_STEPS = 6'h29;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TPDC_IDLE,
    TPDC_CORE,
    TPDC_MEM,
    TPDC_PIX
  } tpdc_state_t;

endpackage

// ===== core/tpdc_freq_calc.sv
// sequential calculator: freq = ref * mult / (pre_div * (post_sel + 1))
// assumes inputs are stable in the cycle of start; one job at a time
`timescale 1ns/1ps
module tpdc_freq_calc
  import tpdc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [31:0] ref_khz,
  input wire logic [8:0] mult,
  input wire logic [4:0] pre_div,
  input wire logic [1:0] post_sel,
  output logic busy,
  output logic done,
  output logic [31:0] freq_khz
);

  logic [PROD_W-1:0] dvd_reg;
  logic [PROD_W-1:0] quo_reg;
  logic [PROD_W-1:0] prod_reg;
  logic [DIV_W:0] rem_reg;
  logic [DIV_W-1:0] div_reg;
  logic [5:0] cnt_reg;
  logic [PROD_W-1:0] product;
  logic [DIV_W-1:0] divisor;
  logic [DIV_W:0] rem_shift;
  logic sub_ok;
  logic [PROD_W-1:0] quo_full;

  // post-divide code n divides by n+1
  assign product = PROD_W'(ref_khz) * PROD_W'(mult);
  assign divisor = DIV_W'(pre_div) * DIV_W'({1'b0, post_sel} + 3'h1);
  assign rem_shift = {rem_reg[DIV_W-1:0], dvd_reg[PROD_W-1]};
  assign sub_ok = rem_shift >= {1'b0, div_reg};
  assign quo_full = {quo_reg[PROD_W-2:0], sub_ok};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      freq_khz <= 32'h0;
      cnt_reg <= 6'h0;
      dvd_reg <= '0;
      quo_reg <= '0;
      prod_reg <= '0;
      rem_reg <= '0;
      div_reg <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        cnt_reg <= CALC_STEPS;
        dvd_reg <= product;
        prod_reg <= product;
        div_reg <= divisor;
        quo_reg <= '0;
        rem_reg <= '0;
      end else if (busy) begin
        dvd_reg <= {dvd_reg[PROD_W-2:0], 1'b0};
        rem_reg <= sub_ok ? rem_shift - {1'b0, div_reg} : rem_shift;
        quo_reg <= quo_full;
        cnt_reg <= cnt_reg - 6'h1;
        if (cnt_reg == 6'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
          // zero divisor gives zero; overflow saturates
          if (div_reg == '0) begin
            freq_khz <= 32'h0;
          end else if (|quo_full[PROD_W-1:32]) begin
            freq_khz <= 32'hFFFF_FFFF;
          end else begin
            freq_khz <= quo_full[31:0];
          end
        end
      end
    end
  end

  // checks
  logic [PROD_W+DIV_W:0] chk_low;
  logic [PROD_W+DIV_W:0] chk_prod;
  assign chk_low = (PROD_W+DIV_W+1)'(quo_reg) * (PROD_W+DIV_W+1)'(div_reg);
  assign chk_prod = (PROD_W+DIV_W+1)'(prod_reg);

  calc_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (start && !busy) |-> ##42 done)
    else $error("calculator done not 42 cycles after start");
  calc_formula_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (done && div_reg != '0) |-> (chk_low <= chk_prod)
      && (chk_prod < chk_low + (PROD_W+DIV_W+1)'(div_reg)))
    else $error("calculator quotient does not match product over divisor");

endmodule // tpdc_freq_calc

// ===== core/tpdc_top.sv
// What this block does
// - Pixel post-divider code selects divide by 1-4
// - Pixel multiplier nine bits, top bit bit0
// - Pixel clock derives from core clock output
// - Memory pll uses same divider field layout
// - Memory multiplier joins bit0 and second register
// - Memory pll output clocks display memory
// - Core pll uses same three-field arrangement
// - Core pll output clocks core logic
// - Output is ref times mult over both dividers
//
// axi4-lite register file for three pll settings and a frequency model
// assumes one clock, synchronous active-low reset, a compliant master
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module tpdc_top
  import tpdc_pkg::*;
#(
  parameter logic [31:0] CRYSTAL_REF_FREQ_KHZ = 32'h0000_2710
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] core_logic_clock_freq,
  output logic [31:0] display_mem_clock_freq,
  output logic [31:0] pixel_scan_clock_freq,
  output logic freq_settled
);

  // ---------------- bus handshake ----------------
  logic aw_hold_reg;
  logic aw_hold_next;
  logic [ADDR_W-1:0] awaddr_reg;
  logic w_hold_reg;
  logic w_hold_next;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_next;
  logic rvalid_next;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign aw_hold_next = (aw_hold_reg && !wr_fire) || aw_take;
  assign w_hold_next = (w_hold_reg && !wr_fire) || w_take;
  assign bvalid_next = wr_fire || (s_axi_bvalid && !s_axi_bready);
  assign rvalid_next = ar_take || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      s_axi_awready <= !aw_hold_next && !bvalid_next;
      s_axi_wready <= !w_hold_next && !bvalid_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_arready <= !rvalid_next;
      s_axi_rvalid <= rvalid_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= '0;
      wdata_reg <= 8'h0;
      wstrb0_reg <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
    end
  end

  // ---------------- pll control registers ----------------
  logic [NUM_REGS-1:0][7:0] pll_regs;
  logic [NUM_REGS-1:0] wr_hit;
  logic [NUM_REGS-1:0] rd_hit;
  logic [NUM_REGS-1:0][7:0] rd_term;
  logic wr_any_pll;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      assign wr_hit[gi] = wr_fire && (awaddr_reg == ADDR_W'({REG_IDX[gi][5:0], 2'b00}));
      assign rd_hit[gi] = s_axi_araddr == ADDR_W'({REG_IDX[gi][5:0], 2'b00});
      assign rd_term[gi] = rd_hit[gi] ? pll_regs[gi] : 8'h0;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pll_regs[gi] <= REG_RST[gi];
        end else if (wr_hit[gi] && wstrb0_reg) begin
          pll_regs[gi] <= wdata_reg;
        end
      end
    end
  endgenerate

  assign wr_any_pll = |wr_hit;

  // per-pll fields; n is bit 0 of the first register over the whole second
  logic [1:0] core_post;
  logic [1:0] mem_post;
  logic [1:0] pix_post;
  logic [4:0] core_pre;
  logic [4:0] mem_pre;
  logic [4:0] pix_pre;
  logic [8:0] core_mult;
  logic [8:0] mem_mult;
  logic [8:0] pix_mult;

  assign pix_post = pll_regs[SLOT_PIX_A][POST_HI:POST_LO];
  assign mem_post = pll_regs[SLOT_MEM_A][POST_HI:POST_LO];
  assign core_post = pll_regs[SLOT_CORE_A][POST_HI:POST_LO];
  assign pix_pre = pll_regs[SLOT_PIX_A][PRE_HI:PRE_LO];
  assign mem_pre = pll_regs[SLOT_MEM_A][PRE_HI:PRE_LO];
  assign core_pre = pll_regs[SLOT_CORE_A][PRE_HI:PRE_LO];
  assign pix_mult = {pll_regs[SLOT_PIX_A][N8_BIT], pll_regs[SLOT_PIX_B]};
  assign mem_mult = {pll_regs[SLOT_MEM_A][N8_BIT], pll_regs[SLOT_MEM_B]};
  assign core_mult = {pll_regs[SLOT_CORE_A][N8_BIT], pll_regs[SLOT_CORE_B]};

  // ---------------- recalculation sequencer ----------------
  tpdc_state_t state_reg;
  tpdc_state_t state_next;
  logic dirty_reg;
  logic launch_reg;
  logic calc_start;
  logic calc_busy;
  logic calc_done;
  logic [31:0] calc_freq;
  logic [31:0] calc_ref;
  logic [8:0] calc_mult;
  logic [4:0] calc_pre;
  logic [1:0] calc_post;
  logic calc_bad;
  logic [2:0] bad_reg;

  // pixel reference is the core pll output, the others take the crystal
  assign calc_ref = (state_reg == TPDC_PIX) ? core_logic_clock_freq
                                            : CRYSTAL_REF_FREQ_KHZ;
  assign calc_mult = (state_reg == TPDC_PIX) ? pix_mult :
                     (state_reg == TPDC_MEM) ? mem_mult : core_mult;
  assign calc_pre = (state_reg == TPDC_PIX) ? pix_pre :
                    (state_reg == TPDC_MEM) ? mem_pre : core_pre;
  assign calc_post = (state_reg == TPDC_PIX) ? pix_post :
                     (state_reg == TPDC_MEM) ? mem_post : core_post;
  // flags settings outside the range software is meant to keep
  assign calc_bad = (calc_pre < PRE_MIN) || (calc_mult < MULT_MIN)
                    || (calc_ref < REF_MIN_KHZ * 32'(calc_pre));
  assign calc_start = (state_reg != TPDC_IDLE) && !launch_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TPDC_IDLE: begin
        if (dirty_reg) begin
          state_next = TPDC_CORE;
        end
      end
      TPDC_CORE: begin
        if (calc_done) begin
          state_next = TPDC_MEM;
        end
      end
      TPDC_MEM: begin
        if (calc_done) begin
          state_next = TPDC_PIX;
        end
      end
      TPDC_PIX: begin
        if (calc_done) begin
          state_next = TPDC_IDLE;
        end
      end
      default: begin
        state_next = TPDC_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= TPDC_IDLE;
      dirty_reg <= 1'b1;
      launch_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // a write in the clearing cycle keeps the request pending
      dirty_reg <= wr_any_pll || (dirty_reg && state_reg != TPDC_IDLE);
      launch_reg <= calc_done ? 1'b0 : (launch_reg || calc_start);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_logic_clock_freq <= 32'h0;
      display_mem_clock_freq <= 32'h0;
      pixel_scan_clock_freq <= 32'h0;
      bad_reg <= 3'h0;
      freq_settled <= 1'b0;
    end else begin
      freq_settled <= (state_next == TPDC_IDLE) && !dirty_reg && !wr_any_pll;
      if (calc_done) begin
        case (state_reg)
          TPDC_CORE: begin
            core_logic_clock_freq <= calc_freq;
            bad_reg[0] <= calc_bad;
          end
          TPDC_MEM: begin
            display_mem_clock_freq <= calc_freq;
            bad_reg[1] <= calc_bad;
          end
          TPDC_PIX: begin
            pixel_scan_clock_freq <= calc_freq;
            bad_reg[2] <= calc_bad;
          end
          default: begin
            bad_reg <= bad_reg;
          end
        endcase
      end
    end
  end

  tpdc_freq_calc u_calc (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(calc_start),
    .ref_khz(calc_ref),
    .mult(calc_mult),
    .pre_div(calc_pre),
    .post_sel(calc_post),
    .busy(calc_busy),
    .done(calc_done),
    .freq_khz(calc_freq)
  );

  // ---------------- read data ----------------
  logic [7:0] rd_pll;
  logic rd_status;
  logic rd_mapped;
  logic [7:0] status_val;

  always_comb begin
    rd_pll = 8'h0;
    for (int i = 0; i < NUM_REGS; i++) begin
      rd_pll = rd_pll | rd_term[i];
    end
  end

  assign rd_status = s_axi_araddr == ADDR_W'({IDX_STATUS[5:0], 2'b00});
  assign rd_mapped = (|rd_hit) || rd_status;
  assign status_val = {4'h0, bad_reg, dirty_reg || (state_reg != TPDC_IDLE) || calc_busy};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_rdata <= {24'h0, rd_status ? status_val : rd_pll};
        s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (wr_fire) begin
        s_axi_bresp <= (|wr_hit) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence core_done_s;
    state_reg == TPDC_CORE && calc_done;
  endsequence
  sequence mem_next_s;
    state_reg == TPDC_MEM ##1 (state_reg == TPDC_MEM && launch_reg);
  endsequence

  reset_defaults_a: assert property (disable iff (1'b0)
    !aresetn |=> (pll_regs == REG_RST && !s_axi_awready && !s_axi_arready))
    else $error("pll registers not at defaults after reset");
  pix_div_a: assert property ((calc_start && state_reg == TPDC_PIX) |->
    calc_post == pll_regs[SLOT_PIX_A][POST_HI:POST_LO]
      && calc_pre == pll_regs[SLOT_PIX_A][PRE_HI:PRE_LO])
    else $error("pixel divider fields not taken from its first register");
  mem_mult_join_a: assert property ((calc_start && state_reg == TPDC_MEM) |->
    calc_mult == {pll_regs[SLOT_MEM_A][N8_BIT], pll_regs[SLOT_MEM_B]})
    else $error("memory multiplier not joined from its two registers");
  pix_core_ref_a: assert property ((calc_start && state_reg == TPDC_PIX) |->
    calc_ref == core_logic_clock_freq)
    else $error("pixel pll not referenced to the core output");
  core_xtal_ref_a: assert property ((calc_start && state_reg == TPDC_CORE) |->
    calc_ref == CRYSTAL_REF_FREQ_KHZ && calc_mult == core_mult)
    else $error("core pll not referenced to the crystal");
  seq_order_a: assert property (core_done_s |=> mem_next_s)
    else $error("memory pll not computed right after core pll");
  mem_store_a: assert property ((state_reg == TPDC_MEM && calc_done) |=>
    display_mem_clock_freq == $past(calc_freq))
    else $error("memory clock frequency not stored on completion");
  write_resp_a: assert property (wr_fire |=> s_axi_bvalid [*1] ##0
    (!s_axi_awready && !s_axi_wready))
    else $error("write response missing one cycle after write");
  bad_flag_a: assert property ((state_reg == TPDC_PIX && calc_done
    && calc_pre < PRE_MIN) |=> bad_reg[2])
    else $error("illegal pixel pre-divider not flagged");

endmodule // tpdc_top

// ===== tb/test_tpdc_top.sv
// self-checking bench for the three-pll configuration register block
// assumes tpdc_pkg and tpdc_top are compiled first; the bench is the axi4-lite master
`timescale 1ns/1ps
module test_tpdc_top;
  import tpdc_pkg::*;
  localparam logic [31:0] REF_KHZ = 32'h0000_2710;
  localparam int LIMIT = 80000;
  localparam logic [7:0] RST_TAB [NUM_REGS] = '{8'h14, 8'h3C, 8'h14, 8'h85, 8'h14, 8'h64};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [ADDR_W-1:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [31:0] f_core;
  logic [31:0] f_mem;
  logic [31:0] f_pix;
  logic settled;
  logic [7:0] exp_reg [NUM_REGS];
  integer errors = 0;
  integer n_compared = 0;
  integer cycles = 0;
  integer seed = 32'h81d53303;

  tpdc_top #(.CRYSTAL_REF_FREQ_KHZ(REF_KHZ)) i_tpdc_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_logic_clock_freq(f_core), .display_mem_clock_freq(f_mem),
    .pixel_scan_clock_freq(f_pix), .freq_settled(settled)
  );

  always #20 aclk = ~aclk;

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      $display("BAD %0t: run did not finish in time", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("counts: %0d compared, %0d errors", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [7:0] byte_addr(input int slot);
    return {REG_IDX[slot][5:0], 2'b00};
  endfunction

  // integer model of one synthesiser output, saturating like the design
  function automatic logic [31:0] freq(input logic [31:0] rf, input logic [8:0] n,
                                       input logic [4:0] r, input logic [1:0] post);
    logic [63:0] num;
    logic [63:0] den;
    if (r == 5'h00) return 32'h0000_0000;
    num = {32'h0000_0000, rf} * {55'h0, n};
    den = {59'h0, r} * ({62'h0, post} + 64'h1);
    num = num / den;
    if (num > 64'h0000_0000_FFFF_FFFF) return 32'hFFFF_FFFF;
    return num[31:0];
  endfunction

  task automatic axi_write(input logic [7:0] addr, input logic [7:0] data,
                           input logic [3:0] strb, output logic [1:0] resp);
    logic [31:0] junk;
    junk = $random(seed);
    @(posedge aclk);
    awaddr <= addr;
    awvalid <= 1'b1;
    wdata <= {junk[31:8], data};
    wstrb <= strb;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // waits for the answer; only the cycle ceiling ends a hang
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] addr, output logic [31:0] data,
                          output logic [1:0] resp);
    @(posedge aclk);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic write_reg(input int slot, input logic [7:0] data);
    logic [1:0] r;
    axi_write(byte_addr(slot), data, 4'h1, r);
    check({30'h0, r}, {30'h0, RESP_OKAY}, "write resp");
    exp_reg[slot] = data;
  endtask

  task automatic read_all();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < NUM_REGS; i++) begin
      axi_read(byte_addr(i), d, r);
      check({30'h0, r}, {30'h0, RESP_OKAY}, "read resp");
      check(d, {24'h0, exp_reg[i]}, "readback");
    end
  endtask

  task automatic settle();
    int n;
    n = 0;
    while (settled === 1'b1 && n < 20) begin
      @(posedge aclk);
      n++;
    end
    check({31'h0, settled}, 32'h0, "settled fell");
    n = 0;
    while (settled !== 1'b1 && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    check({31'h0, settled}, 32'h1, "settled");
  endtask

  task automatic check_freqs();
    logic [31:0] core;
    core = freq(REF_KHZ, {exp_reg[4][0], exp_reg[5]}, exp_reg[4][5:1], exp_reg[4][7:6]);
    check(f_core, core, "core freq");
    check(f_mem, freq(REF_KHZ, {exp_reg[2][0], exp_reg[3]}, exp_reg[2][5:1],
                      exp_reg[2][7:6]), "mem freq");
    check(f_pix, freq(core, {exp_reg[0][0], exp_reg[1]}, exp_reg[0][5:1],
                      exp_reg[0][7:6]), "pixel freq");
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) exp_reg[i] = RST_TAB[i];
    @(posedge aclk);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [1:0] post;
    logic [4:0] pre;
    logic [8:0] n;
    int s;
    do_reset();
    read_all();
    settle();
    check_freqs();
    $display("test reset defaults done");
    for (int k = 0; k < 4; k++) begin
      post = k[1:0];
      write_reg(SLOT_CORE_A, {post, 5'h0A, 1'b0});
      settle();
      check_freqs();
    end
    write_reg(SLOT_CORE_A, 8'hD5);
    write_reg(SLOT_CORE_B, 8'h00);
    settle();
    check(f_core, 32'h0000_FA00, "worked example");
    $display("test divider codes done");
    for (int k = 0; k < 30; k++) begin
      s = $unsigned($random(seed)) % 3;
      post = 2'($random(seed));
      pre = 5'h02 + 5'($unsigned($random(seed)) % 9);
      n = 9'h002 + 9'($unsigned($random(seed)) % 510);
      write_reg(2 * s, {post, pre, n[8]});
      write_reg(2 * s + 1, n[7:0]);
      settle();
      check_freqs();
      if (k % 10 == 0) read_all();
    end
    $display("test random settings done");
    axi_read(8'h40, d, r);
    check(d[ST_BUSY], 1'b0, "busy idle");
    write_reg(SLOT_CORE_A, 8'h00);
    write_reg(SLOT_PIX_A, 8'h02);
    settle();
    check_freqs();
    axi_read(8'h40, d, r);
    check(d[ST_BAD_CORE], 1'b1, "core flagged");
    check(d[ST_BAD_PIX], 1'b1, "pixel flagged");
    axi_write(8'h40, 8'hFF, 4'h1, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR}, "status write");
    axi_write(8'h3C, 8'h5A, 4'h1, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_read(8'h3C, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    check(d, 32'h0000_0000, "unmapped data");
    axi_write(byte_addr(SLOT_PIX_A), 8'hAA, 4'h0, r);
    check({30'h0, r}, {30'h0, RESP_OKAY}, "masked write");
    read_all();
    $display("test responses done");
    do_reset();
    read_all();
    settle();
    check_freqs();
    $display("test second reset done");
    stop_test();
  end
endmodule // test_tpdc_top
